/* File: rtl/pin_sync.v */
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Pin is asynchronous to clk
// Notes:   Output changes only when stages two and three agree
`include "xor_tree_defines.vh"

module pin_sync #(
   parameter RESET_LEVEL = 1'b0
) (
   // Clock and reset
   input  wire clk,
   input  wire nrst,
   // Pin and result
   input  wire pin,
   output reg  level
);

   reg s1;
   reg s2;
   reg s3;

   always @(posedge clk) begin
      if (!nrst) begin
         s1    <= RESET_LEVEL;
         s2    <= RESET_LEVEL;
         s3    <= RESET_LEVEL;
         level <= RESET_LEVEL;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level <= s3;
         end
      end
   end

endmodule

/* File: rtl/xor_tree_defines.vh */
// Purpose: Constants for the board-level XOR-tree solder test port
// Assumes: Included by bare name from the design files
// Notes:   Instruction codes are 8 bits wide
`ifndef XOR_TREE_DEFINES_VH
`define XOR_TREE_DEFINES_VH

`define IR_WIDTH        8
`define IR_XOR_TREE     8'h08
`define IR_BYPASS       8'hff
`define IR_RESET_VALUE  8'h01
`define IR_CAPTURE      8'h01

// Test-port controller states
`define TS_RESET        4'h0
`define TS_IDLE         4'h1
`define TS_SEL_DR       4'h2
`define TS_CAP_DR       4'h3
`define TS_SHIFT_DR     4'h4
`define TS_EXIT1_DR     4'h5
`define TS_PAUSE_DR     4'h6
`define TS_EXIT2_DR     4'h7
`define TS_UPD_DR       4'h8
`define TS_SEL_IR       4'h9
`define TS_CAP_IR       4'ha
`define TS_SHIFT_IR     4'hb
`define TS_EXIT1_IR     4'hc
`define TS_PAUSE_IR     4'hd
`define TS_EXIT2_IR     4'he
`define TS_UPD_IR       4'hf

`endif

/* File: rtl/xor_tree_test_port.v */
// Purpose: Test port with 8-bit instruction register and XOR-tree solder test
// Assumes: Test clock and all pins are asynchronous to clk; control pins are sampled by it, tree balls are not
// Notes:   Tree path to the data-out pin is combinational; every other
//          output is registered
`include "xor_tree_defines.vh"

module xor_tree_test_port #(
   parameter TREE_WIDTH = 53
) (
   // Clock and reset
   input  wire                  clk,
   input  wire                  nrst,
   // Test-port pins, shared with functional pins
   input  wire                  test_port_reset_pin,
   input  wire                  display_channel_data_pin,
   input  wire                  serial_data_pin,
   input  wire                  serial_clock_pin,
   output reg                   hot_plug_detect_pin_out,
   output reg                   hot_plug_detect_pin_oe,
   // Link reference clock pair, qualifies the I/Os
   input  wire                  cpu_link_ref_clock_p,
   input  wire                  cpu_link_ref_clock_n,
   // Tree input balls
   input  wire [TREE_WIDTH-1:0] tree_in,
   // Mode indications to the rest of the chip
   output reg                   tree_mode,
   output reg                   pins_input_only,
   output reg                   tree_ready,
   output reg                   io_enable,
   output reg  [`IR_WIDTH-1:0]  instruction
);

   // ---------------------------------------------------------------
   // Pin sampling
   // ---------------------------------------------------------------
   wire tmode_s;
   wire tms_s;
   wire tdi_s;
   wire tck_s;
   wire refp_s;
   wire refn_s;

   // Reset pin is active high: it holds the test port in reset
   pin_sync #(.RESET_LEVEL(1'b1)) u_rst (.clk(clk), .nrst(nrst),
      .pin(test_port_reset_pin), .level(tmode_s));
   pin_sync #(.RESET_LEVEL(1'b1)) u_tms (.clk(clk), .nrst(nrst),
      .pin(display_channel_data_pin), .level(tms_s));
   pin_sync #(.RESET_LEVEL(1'b0)) u_tdi (.clk(clk), .nrst(nrst),
      .pin(serial_data_pin), .level(tdi_s));
   pin_sync #(.RESET_LEVEL(1'b0)) u_tck (.clk(clk), .nrst(nrst),
      .pin(serial_clock_pin), .level(tck_s));
   pin_sync #(.RESET_LEVEL(1'b0)) u_rfp (.clk(clk), .nrst(nrst),
      .pin(cpu_link_ref_clock_p), .level(refp_s));
   pin_sync #(.RESET_LEVEL(1'b0)) u_rfn (.clk(clk), .nrst(nrst),
      .pin(cpu_link_ref_clock_n), .level(refn_s));

   reg  tck_q;
   wire tck_rise = tck_s & ~tck_q;
   wire tck_fall = ~tck_s & tck_q;

   // ---------------------------------------------------------------
   // Test-port controller
   // ---------------------------------------------------------------
   reg [3:0]           state;
   reg [3:0]           next_state;
   reg [`IR_WIDTH-1:0] ir_shift;
   reg                 bypass_bit;
   reg                 tdo_shift;
   reg                 shifting;

   // Controller states, binary codes from the header
   localparam [3:0] TEST_RESET = `TS_RESET;
   localparam [3:0] RUN_IDLE   = `TS_IDLE;
   localparam [3:0] SELECT_DR  = `TS_SEL_DR;
   localparam [3:0] CAPTURE_DR = `TS_CAP_DR;
   localparam [3:0] SHIFT_DR   = `TS_SHIFT_DR;
   localparam [3:0] EXIT1_DR   = `TS_EXIT1_DR;
   localparam [3:0] PAUSE_DR   = `TS_PAUSE_DR;
   localparam [3:0] EXIT2_DR   = `TS_EXIT2_DR;
   localparam [3:0] UPDATE_DR  = `TS_UPD_DR;
   localparam [3:0] SELECT_IR  = `TS_SEL_IR;
   localparam [3:0] CAPTURE_IR = `TS_CAP_IR;
   localparam [3:0] SHIFT_IR   = `TS_SHIFT_IR;
   localparam [3:0] EXIT1_IR   = `TS_EXIT1_IR;
   localparam [3:0] PAUSE_IR   = `TS_PAUSE_IR;
   localparam [3:0] EXIT2_IR   = `TS_EXIT2_IR;
   localparam [3:0] UPDATE_IR  = `TS_UPD_IR;

   // Code in force after this test-clock edge; going straight from
   // Update-IR to Run-Test/Idle must already see the new code
   wire [`IR_WIDTH-1:0] next_instruction = (state == UPDATE_IR)  ? ir_shift :
                                           (state == TEST_RESET) ? `IR_RESET_VALUE :
                                           instruction;

   always @* begin
      case (state)
         TEST_RESET: next_state = tms_s ? TEST_RESET : RUN_IDLE;
         RUN_IDLE:   next_state = tms_s ? SELECT_DR  : RUN_IDLE;
         SELECT_DR:  next_state = tms_s ? SELECT_IR  : CAPTURE_DR;
         CAPTURE_DR: next_state = tms_s ? EXIT1_DR   : SHIFT_DR;
         SHIFT_DR:   next_state = tms_s ? EXIT1_DR   : SHIFT_DR;
         EXIT1_DR:   next_state = tms_s ? UPDATE_DR  : PAUSE_DR;
         PAUSE_DR:   next_state = tms_s ? EXIT2_DR   : PAUSE_DR;
         EXIT2_DR:   next_state = tms_s ? UPDATE_DR  : SHIFT_DR;
         UPDATE_DR:  next_state = tms_s ? SELECT_DR  : RUN_IDLE;
         SELECT_IR:  next_state = tms_s ? TEST_RESET : CAPTURE_IR;
         CAPTURE_IR: next_state = tms_s ? EXIT1_IR   : SHIFT_IR;
         SHIFT_IR:   next_state = tms_s ? EXIT1_IR   : SHIFT_IR;
         EXIT1_IR:   next_state = tms_s ? UPDATE_IR  : PAUSE_IR;
         PAUSE_IR:   next_state = tms_s ? EXIT2_IR   : PAUSE_IR;
         EXIT2_IR:   next_state = tms_s ? UPDATE_IR  : SHIFT_IR;
         UPDATE_IR:  next_state = tms_s ? SELECT_DR  : RUN_IDLE;
         default:    next_state = TEST_RESET;
      endcase
   end

   // Reset pin acts without a test-clock edge, as an async reset would
   always @(posedge clk) begin
      if (!nrst) begin
         tck_q       <= 1'b0;
         state       <= TEST_RESET;
         ir_shift    <= `IR_RESET_VALUE;
         instruction <= `IR_RESET_VALUE;
         bypass_bit  <= 1'b0;
         tdo_shift   <= 1'b0;
         shifting    <= 1'b0;
         tree_ready  <= 1'b0;
      end else begin
         tck_q <= tck_s;
         if (tmode_s) begin
            state       <= TEST_RESET;
            instruction <= `IR_RESET_VALUE;
            ir_shift    <= `IR_RESET_VALUE;
            shifting    <= 1'b0;
            tree_ready  <= 1'b0;
         end else begin
            if (tck_rise) begin
               state <= next_state;
               case (state)
                  CAPTURE_IR: ir_shift <= `IR_CAPTURE;
                  SHIFT_IR:   ir_shift <= {tdi_s, ir_shift[`IR_WIDTH-1:1]};
                  CAPTURE_DR: bypass_bit <= 1'b0;
                  SHIFT_DR:   bypass_bit <= tdi_s;
                  UPDATE_IR: begin
                     instruction <= ir_shift;
                     tree_ready  <= 1'b0;
                  end
                  TEST_RESET: instruction <= `IR_RESET_VALUE;
                  default: begin
                  end
               endcase
               // Initialisation completes on reaching Run-Test/Idle
               if (next_state == RUN_IDLE && next_instruction == `IR_XOR_TREE) begin
                  tree_ready <= 1'b1;
               end
            end
            if (tck_fall) begin
               shifting  <= (state == SHIFT_IR) || (state == SHIFT_DR);
               tdo_shift <= (state == SHIFT_IR) ? ir_shift[0] : bypass_bit;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // I/O enable from reference clock activity
   // ---------------------------------------------------------------
   reg refp_q;

   always @(posedge clk) begin
      if (!nrst) begin
         refp_q    <= 1'b0;
         io_enable <= 1'b0;
      end else begin
         refp_q <= refp_s;
         // Enabled once the pair is seen complementary and toggling
         if (tmode_s) begin
            io_enable <= 1'b0;
         end else if (refp_s != refp_q && refp_s != refn_s) begin
            io_enable <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Tree and data-out pin
   // ---------------------------------------------------------------
   // Reduction XOR has no notion of order; start pin joins unsynchronised
   wire tree_out = serial_data_pin ^ (^tree_in);

   wire tree_sel = (instruction == `IR_XOR_TREE) && !tmode_s;

   always @(posedge clk) begin
      if (!nrst) begin
         tree_mode       <= 1'b0;
         pins_input_only <= 1'b0;
         hot_plug_detect_pin_oe <= 1'b0;
      end else begin
         tree_mode       <= tree_sel;
         pins_input_only <= tree_sel;
         hot_plug_detect_pin_oe <= tree_sel || shifting;
      end
   end

   // Registered mux select, combinational tree data into the pin
   always @* begin
      if (tree_mode) begin
         hot_plug_detect_pin_out = tree_out;
      end else begin
         hot_plug_detect_pin_out = tdo_shift;
      end
   end

endmodule

/* File: tb/xor_tester.sv */
// Purpose: Boundary tester model for the test port
// Assumes: TCK half period of 8 bench clocks (160 ns period)
// Notes:   TCK rests low between operations
module xor_tester (
   // Bench clock
   input  logic clk,
   // Test-port pins
   output logic tck,
   output logic tms,
   output logic tdi,
   // Reference pair
   output logic ref_p,
   output logic ref_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      ref_p = 1'b0;
   end
   always #50 ref_p = ~ref_p;
   assign ref_n = ~ref_p;
   // TMS and TDI move only while TCK is low
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      repeat (8) @(negedge clk);
      // Slower than the recommended test-clock rate, for sync margin
      tck = 1'b1;
      repeat (8) @(negedge clk);
      tck = 1'b0;
   endtask
   task automatic load_ir(input logic [7:0] code);
      int i;
      for (i = 0; i < 5; i++) step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      for (i = 0; i < 8; i++) step(i == 7, code[i]);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic set_start(input logic v);
      tdi = v;
   endtask
endmodule

/* File: tb/xor_tree_checker.sv */
// Purpose: Port-level checks for the XOR-tree test port
// Assumes: Bound to the design top; sync reset nrst
// Notes:   Tree output is compared in the cycle it is sampled
module xor_tree_checker #(
   parameter TREE_WIDTH = 53
) (
   // Clock and reset
   input logic                  clk,
   input logic                  nrst,
   // Watched ports
   input logic                  test_port_reset_pin,
   input logic                  serial_data_pin,
   input logic                  hot_plug_detect_pin_out,
   input logic                  hot_plug_detect_pin_oe,
   input logic [TREE_WIDTH-1:0] tree_in,
   input logic                  tree_mode,
   input logic                  pins_input_only,
   input logic                  tree_ready,
   input logic                  io_enable,
   input logic [7:0]            instruction
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_tree_out_parity: assert property (tree_mode |->
      hot_plug_detect_pin_out == (serial_data_pin ^ (^tree_in))) else $error("tree output");
   chk_oe_in_tree: assert property (tree_mode |-> hot_plug_detect_pin_oe)
      else $error("tdo not driven");
   chk_pins_follow: assert property (pins_input_only == tree_mode)
      else $error("input-only flag");
   chk_mode_code: assert property (tree_mode |-> $past(instruction) == 8'h08)
      else $error("mode without code");
   chk_mode_entry: assert property (($rose(instruction == 8'h08)
      && !test_port_reset_pin) |=> tree_mode) else $error("mode not entered");
   chk_reset_pin_clears: assert property (test_port_reset_pin [*8] |->
      instruction == 8'h01 && !tree_ready && !io_enable) else $error("port reset");
   chk_ready_code: assert property ($rose(tree_ready) |-> instruction == 8'h08)
      else $error("ready without code");
   chk_one_toggle: assert property ((tree_mode && $past(tree_mode)
      && $stable(serial_data_pin) && $countones(tree_in ^ $past(tree_in)) == 1)
      |-> hot_plug_detect_pin_out != $past(hot_plug_detect_pin_out)) else $error("no toggle");
endmodule

bind xor_tree_test_port xor_tree_checker #(.TREE_WIDTH(TREE_WIDTH)) u_xor_tree_checker (
   .clk(clk), .nrst(nrst), .test_port_reset_pin(test_port_reset_pin),
   .serial_data_pin(serial_data_pin), .hot_plug_detect_pin_out(hot_plug_detect_pin_out),
   .hot_plug_detect_pin_oe(hot_plug_detect_pin_oe), .tree_in(tree_in),
   .tree_mode(tree_mode), .pins_input_only(pins_input_only), .tree_ready(tree_ready),
   .io_enable(io_enable), .instruction(instruction));

/* File: tb/xor_tree_test_port_tb.sv */
// Purpose: Self-checking bench for the XOR-tree test port
// Assumes: 100 MHz clk, inputs driven on its falling edge
// Notes:   Every tree ball is driven to a defined level throughout
module xor_tree_test_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TW = 53;
   logic clk = 1'b0, nrst = 1'b0, rst_pin = 1'b0;
   logic tck, tms, tdi, ref_p, ref_n, hpd_out, hpd_oe, tmode, pin_in, trdy, io_en;
   logic [TW-1:0] tree = '0;
   logic [7:0] instr;
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   always #5 clk = ~clk;
   xor_tester u_xor_tester (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .ref_p(ref_p),
      .ref_n(ref_n));
   xor_tree_test_port #(.TREE_WIDTH(TW)) u_xor_tree_test_port (.clk(clk), .nrst(nrst),
      .test_port_reset_pin(rst_pin), .display_channel_data_pin(tms), .serial_data_pin(tdi),
      .serial_clock_pin(tck), .hot_plug_detect_pin_out(hpd_out),
      .hot_plug_detect_pin_oe(hpd_oe), .cpu_link_ref_clock_p(ref_p),
      .cpu_link_ref_clock_n(ref_n), .tree_in(tree), .tree_mode(tmode),
      .pins_input_only(pin_in), .tree_ready(trdy), .io_enable(io_en), .instruction(instr));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Neighbouring code must not open the tree
   task automatic t_other_code;
      u_xor_tester.load_ir(8'h09);
      repeat (8) @(negedge clk);
      cmp(instr, 8'h09);
      cmp(8'(tmode), 8'h00);
      cmp(8'(pin_in), 8'h00);
      cmp(8'(hpd_oe), 8'h00);
   endtask
   // Capture value leaves on the data-out pin during Shift-IR
   task automatic t_capture;
      u_xor_tester.step(1'b1, 1'b0);
      u_xor_tester.step(1'b1, 1'b0);
      u_xor_tester.step(1'b0, 1'b0);
      u_xor_tester.step(1'b0, 1'b0);
      repeat (8) @(negedge clk);
      cmp({6'h00, hpd_oe, hpd_out}, 8'h03);
      u_xor_tester.step(1'b1, 1'b0);
      repeat (8) @(negedge clk);
      cmp({6'h00, hpd_oe, hpd_out}, 8'h00);
      u_xor_tester.step(1'b1, 1'b0);
      u_xor_tester.step(1'b0, 1'b0);
      repeat (8) @(negedge clk);
      cmp(instr, 8'h00);
   endtask
   task automatic t_tree;
      int i;
      int k;
      u_xor_tester.load_ir(8'h08);
      u_xor_tester.set_start(1'b1);
      for (k = 0; k < 20 && trdy !== 1'b1; k++) @(negedge clk);
      cmp(8'(trdy), 8'h01);
      cmp(8'(tmode), 8'h01);
      cmp(8'(pin_in), 8'h01);
      cmp(8'(hpd_oe), 8'h01);
      cmp(8'(io_en), 8'h01);
      for (i = 0; i <= TW; i++) begin
         if (i > 0) tree[i-1] = 1'b1;
         #1 cmp({7'h00, hpd_out}, {7'h00, ~i[0]});
         @(negedge clk);
      end
      u_xor_tester.set_start(1'b0);
      tree = 53'ha5f3c9e017d24;
      #1 cmp(8'(hpd_out), 8'($countones(tree) & 1));
      @(negedge clk);
      tree = {<<{tree}};
      #1 cmp(8'(hpd_out), 8'($countones(tree) & 1));
      @(negedge clk);
   endtask
   task automatic t_reset_pin;
      rst_pin = 1'b1;
      repeat (10) @(negedge clk);
      cmp(instr, 8'h01);
      cmp(8'(tmode), 8'h00);
      cmp(8'(trdy), 8'h00);
      cmp(8'(io_en), 8'h00);
      rst_pin = 1'b0;
      repeat (6) @(negedge clk);
   endtask
   initial begin
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (5) @(negedge clk);
      t_other_code;
      t_capture;
      t_tree;
      t_reset_pin;
      tally_and_finish;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish;
      end
   end
endmodule
